/* File: logic/timer8_pkg.sv */
/*
 * Shared constants for the 8-bit timer compare output unit: register
 * offsets, field positions, reset values and the counting-mode type.
 * Assumes a 32-bit APB slave with byte addresses, one word per register.
 */
`default_nettype none

package timer8_pkg;

	// ********************************
	// register byte offsets
	// ********************************
	localparam logic [7:0] OFF_CONTROL_A = 8'h00;
	localparam logic [7:0] OFF_CONTROL_B = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam logic [7:0] OFF_CMP_A = 8'h0C;
	localparam logic [7:0] OFF_CMP_B = 8'h10;
	localparam logic [7:0] OFF_WAVE = 8'h14;

	// ********************************
	// field positions
	// ********************************
	localparam int MODE_A_HI = 7;
	localparam int MODE_A_LO = 6;
	localparam int MODE_B_HI = 5;
	localparam int MODE_B_LO = 4;
	localparam int GEN_LO_HI = 1;
	localparam int GEN_LO_LO = 0;
	localparam int FORCE_A_BIT = 7;
	localparam int FORCE_B_BIT = 6;
	localparam int GEN_HI_BIT = 3;
	localparam int RUN_BIT = 0;
	localparam int WAVE_A_BIT = 0;
	localparam int WAVE_B_BIT = 1;
	localparam int DOWN_BIT = 2;

	// ********************************
	// reset values and limits
	// ********************************
	localparam logic [7:0] CONTROL_A_RESET = 8'h00;
	localparam logic [7:0] CONTROL_B_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] CONTROL_A_READ_MASK = 8'hF3;

	// counting sequence selected by the three generation mode bits
	typedef enum logic [1:0] {
		KIND_NORMAL = 2'b00,
		KIND_CTC = 2'b01,
		KIND_FAST = 2'b10,
		KIND_PHASE = 2'b11
	} count_kind_t;

endpackage : timer8_pkg

`default_nettype wire

/* File: logic/timer8_core.sv */
/*
 * 8-bit counter that feeds the compare output unit: count value, TOP flag,
 * direction and PWM kind. Assumes one clock; the counter steps every clock
 * while run is high, and software may load it at any time.
 */
`timescale 1ns/10ps
`default_nettype none

module timer8_core import timer8_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [2:0] wave_gen_mode,
	input wire logic [7:0] top_a,
	input wire logic cnt_we,
	input wire logic [7:0] cnt_wdata,
	output logic [7:0] count,
	output logic counting_down,
	output logic at_top,
	output logic pwm_fast,
	output logic pwm_phase
);

	count_kind_t kind;
	logic [7:0] top;
	logic [7:0] next_count;
	logic next_down;

	// ********************************
	// mode decode: only the generation bits shape counting
	// ********************************
	always_comb begin
		case (wave_gen_mode)
			3'b001, 3'b101: kind = KIND_PHASE;
			3'b011, 3'b111: kind = KIND_FAST;
			3'b010: kind = KIND_CTC;
			default: kind = KIND_NORMAL; // reserved codes count as normal
		endcase
	end

	// top is the A compare value in the three modes that use it
	assign top = (wave_gen_mode == 3'b010 || wave_gen_mode[2] && wave_gen_mode[0]) ?
		top_a : COUNT_MAX;
	assign at_top = (count == top);
	assign pwm_fast = (kind == KIND_FAST);
	assign pwm_phase = (kind == KIND_PHASE);

	// ********************************
	// next count and direction
	// ********************************
	always_comb begin
		next_count = count;
		next_down = counting_down;
		if (kind == KIND_PHASE) begin
			if (!counting_down && at_top || counting_down && count == COUNT_BOTTOM) begin
				next_down = !counting_down;
			end
			next_count = next_down ? count - 8'h01 : count + 8'h01;
		end else begin
			next_down = 1'b0;
			next_count = at_top ? COUNT_BOTTOM : count + 8'h01;
		end
	end

	// counter register; a software load wins over stepping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= COUNT_BOTTOM;
			counting_down <= 1'b0;
		end else if (cnt_we) begin
			count <= cnt_wdata;
		end else if (run) begin
			count <= next_count;
			counting_down <= next_down;
		end
	end

endmodule : timer8_core

`default_nettype wire

/* File: logic/wave_out_chan.sv */
/*
 * One compare output channel: holds the waveform output bit and applies the
 * compare action for the current mode. Assumes match, TOP and direction come
 * from the counter of the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module wave_out_chan (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] cmp_out_mode_chan,
	input wire logic pwm_fast,
	input wire logic pwm_phase,
	input wire logic match,
	input wire logic at_top,
	input wire logic cmp_eq_top,
	input wire logic counting_down,
	input wire logic force_cmp_strobe,
	input wire logic preset_we,
	input wire logic preset_val,
	output logic wave_out_chan
);

	logic next_wave;

	// ********************************
	// compare action; mode is read live, so a new mode acts at the next match, or at TOP in fast PWM
	// ********************************
	always_comb begin
		next_wave = wave_out_chan;
		if (preset_we) begin
			next_wave = preset_val;
		end else if (pwm_fast) begin
			if (at_top && cmp_out_mode_chan[1]) begin
				next_wave = !cmp_out_mode_chan[0];
			end else if (match && cmp_out_mode_chan[1]) begin
				next_wave = cmp_out_mode_chan[0];
			end
		end else if (pwm_phase) begin
			if (match && cmp_out_mode_chan[1]) begin
				// a match at top is taken as the down-count action
				next_wave = (counting_down || cmp_eq_top) ?
					!cmp_out_mode_chan[0] : cmp_out_mode_chan[0];
			end
		end else if (match || force_cmp_strobe) begin
			case (cmp_out_mode_chan)
				2'b01: next_wave = !wave_out_chan;
				2'b10: next_wave = 1'b0;
				2'b11: next_wave = 1'b1;
				default: next_wave = wave_out_chan;
			endcase
		end
	end

	// waveform output register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_out_chan <= 1'b0;
		end else begin
			wave_out_chan <= next_wave;
		end
	end

endmodule : wave_out_chan

`default_nettype wire

/* File: logic/timer8_compare_output_unit.sv */
/*
 * Compare match output unit of an 8-bit timer with two channels, an APB
 * register slave and the pin override for each waveform output.
 * Assumes the port block supplies the general pin data and direction bits
 * and combines the returned value and enable onto the pad.
 */
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module timer8_compare_output_unit import timer8_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic port_data_a,
	input wire logic port_data_b,
	input wire logic wave_pin_direction_a,
	input wire logic wave_pin_direction_b,
	output logic wave_pin_a,
	output logic wave_pin_a_oe,
	output logic wave_pin_b,
	output logic wave_pin_b_oe
);

	// ********************************
	// registers and internal signals
	// ********************************
	logic [7:0] timer8_control_a;
	logic [7:0] timer8_control_b;
	logic [7:0] cmp_value_a;
	logic [7:0] cmp_value_b;
	logic [1:0] cmp_out_mode_a;
	logic [1:0] cmp_out_mode_b;
	logic [2:0] wave_gen_mode;
	logic run;
	logic access;
	logic bus_wr;
	logic setup_rd;
	logic mapped;
	logic [31:0] next_rdata;
	logic [7:0] count;
	logic counting_down;
	logic at_top;
	logic pwm_fast;
	logic pwm_phase;
	logic match_a;
	logic match_b;
	logic force_a;
	logic force_b;
	logic wave_out_a;
	logic wave_out_b;
	logic preset_we;
	logic cnt_we;

	assign cmp_out_mode_a = timer8_control_a[MODE_A_HI:MODE_A_LO];
	assign cmp_out_mode_b = timer8_control_a[MODE_B_HI:MODE_B_LO];
	// three-bit generation mode, high bit lives in the second control register
	assign wave_gen_mode = {timer8_control_b[GEN_HI_BIT],
		timer8_control_a[GEN_LO_HI:GEN_LO_LO]};
	assign run = timer8_control_b[RUN_BIT];

	// ********************************
	// APB decode
	// ********************************
	// the slave never waits, so every access phase completes in one cycle
	assign access = psel && penable;
	assign bus_wr = access && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready = access;
	assign mapped = (paddr == OFF_CONTROL_A) || (paddr == OFF_CONTROL_B) ||
		(paddr == OFF_COUNT) || (paddr == OFF_CMP_A) ||
		(paddr == OFF_CMP_B) || (paddr == OFF_WAVE);
	assign pslverr = access && !mapped;
	assign cnt_we = bus_wr && paddr == OFF_COUNT;
	assign preset_we = bus_wr && paddr == OFF_WAVE;
	// strobes exist only for the write cycle and are never stored
	assign force_a = bus_wr && paddr == OFF_CONTROL_B && pwdata[FORCE_A_BIT];
	assign force_b = bus_wr && paddr == OFF_CONTROL_B && pwdata[FORCE_B_BIT];

	// control and compare registers, written at the access edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer8_control_a <= CONTROL_A_RESET;
			timer8_control_b <= CONTROL_B_RESET;
			cmp_value_a <= CMP_RESET;
			cmp_value_b <= CMP_RESET;
		end else if (bus_wr) begin
			case (paddr)
				OFF_CONTROL_A: timer8_control_a <= pwdata[7:0] & CONTROL_A_READ_MASK;
				OFF_CONTROL_B: begin
					timer8_control_b[GEN_HI_BIT] <= pwdata[GEN_HI_BIT];
					timer8_control_b[RUN_BIT] <= pwdata[RUN_BIT];
				end
				OFF_CMP_A: cmp_value_a <= pwdata[7:0];
				OFF_CMP_B: cmp_value_b <= pwdata[7:0];
				default: timer8_control_b <= timer8_control_b;
			endcase
		end
	end

	// ********************************
	// read data
	// ********************************
	// captured in the setup cycle so prdata comes straight from a flop
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			OFF_CONTROL_A: next_rdata[7:0] = timer8_control_a & CONTROL_A_READ_MASK;
			OFF_CONTROL_B: begin
				next_rdata[GEN_HI_BIT] = timer8_control_b[GEN_HI_BIT];
				next_rdata[RUN_BIT] = timer8_control_b[RUN_BIT];
			end
			OFF_COUNT: next_rdata[7:0] = count;
			OFF_CMP_A: next_rdata[7:0] = cmp_value_a;
			OFF_CMP_B: next_rdata[7:0] = cmp_value_b;
			OFF_WAVE: begin
				next_rdata[WAVE_A_BIT] = wave_out_a;
				next_rdata[WAVE_B_BIT] = wave_out_b;
				next_rdata[DOWN_BIT] = counting_down;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata <= next_rdata;
		end
	end

	// ********************************
	// counter and channels
	// ********************************
	timer8_core u_core (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.wave_gen_mode(wave_gen_mode),
		.top_a(cmp_value_a),
		.cnt_we(cnt_we),
		.cnt_wdata(pwdata[7:0]),
		.count(count),
		.counting_down(counting_down),
		.at_top(at_top),
		.pwm_fast(pwm_fast),
		.pwm_phase(pwm_phase)
	);

	// a stopped counter must not repeat the same match every clock
	assign match_a = run && count == cmp_value_a;
	assign match_b = run && count == cmp_value_b;

	wave_out_chan u_chan_a (
		.pclk(pclk),
		.presetn(presetn),
		.cmp_out_mode_chan(cmp_out_mode_a),
		.pwm_fast(pwm_fast),
		.pwm_phase(pwm_phase),
		.match(match_a),
		.at_top(run && at_top),
		.cmp_eq_top(at_top),
		.counting_down(counting_down),
		.force_cmp_strobe(force_a),
		.preset_we(preset_we),
		.preset_val(pwdata[WAVE_A_BIT]),
		.wave_out_chan(wave_out_a)
	);

	wave_out_chan u_chan_b (
		.pclk(pclk),
		.presetn(presetn),
		.cmp_out_mode_chan(cmp_out_mode_b),
		.pwm_fast(pwm_fast),
		.pwm_phase(pwm_phase),
		.match(match_b),
		.at_top(run && at_top),
		.cmp_eq_top(cmp_value_b == count && at_top),
		.counting_down(counting_down),
		.force_cmp_strobe(force_b),
		.preset_we(preset_we),
		.preset_val(pwdata[WAVE_B_BIT]),
		.wave_out_chan(wave_out_b)
	);

	// ********************************
	// pin override
	// ********************************
	// the mode bits alone decide the override; direction stays with the port
	assign wave_pin_a = (cmp_out_mode_a != 2'b00) ? wave_out_a : port_data_a;
	assign wave_pin_b = (cmp_out_mode_b != 2'b00) ? wave_out_b : port_data_b;
	assign wave_pin_a_oe = wave_pin_direction_a;
	assign wave_pin_b_oe = wave_pin_direction_b;

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// quiet cycle: no software write disturbs channel B
	sequence s_quiet;
		!bus_wr;
	endsequence

	sequence s_phase_up_top;
		run && pwm_phase && !counting_down && at_top && !cnt_we;
	endsequence

	// counter sitting on the clear-on-match top while it steps
	sequence s_ctc_top;
		run && !cnt_we && wave_gen_mode == 3'b010 && count == cmp_value_a;
	endsequence

	// force written while a PWM kind is set and the counter stands still
	sequence s_pwm_force;
		force_b && (pwm_fast || pwm_phase) && !run;
	endsequence

	a_override_pin: assert property (
		wave_pin_b == ((cmp_out_mode_b != 2'b00) ? wave_out_b : port_data_b))
		else $error("pin b override wrong");

	a_pin_direction: assert property (
		wave_pin_a_oe == wave_pin_direction_a && wave_pin_b_oe == wave_pin_direction_b)
		else $error("pin enable not following direction");

	a_reserved_read: assert property (
		setup_rd && paddr == OFF_CONTROL_A |=> prdata[3:2] == 2'b00)
		else $error("reserved control bits read nonzero");

	a_mode_zero_hold: assert property (
		match_b && cmp_out_mode_b == 2'b00 ##0 s_quiet |=> $stable(wave_out_b))
		else $error("mode zero changed the output");

	a_toggle_match: assert property (
		match_b && !pwm_fast && !pwm_phase && cmp_out_mode_b == 2'b01 && !bus_wr
		|=> wave_out_b != $past(wave_out_b))
		else $error("toggle on match missing");

	a_force_set: assert property (
		force_b && !pwm_fast && !pwm_phase && cmp_out_mode_b == 2'b11 |=> wave_out_b)
		else $error("forced set not applied");

	a_fast_top: assert property (
		run && pwm_fast && at_top && cmp_out_mode_b == 2'b10 && !bus_wr |=> wave_out_b)
		else $error("fast pwm did not set at top");

	a_fast_match: assert property (
		pwm_fast && match_b && !at_top && cmp_out_mode_b == 2'b10 && !bus_wr |=> !wave_out_b)
		else $error("fast pwm did not clear on match");

	a_phase_up: assert property (
		pwm_phase && match_b && !counting_down && !at_top && cmp_out_mode_b == 2'b11
		&& !bus_wr |=> wave_out_b)
		else $error("phase pwm up-count action wrong");

	a_phase_turn: assert property (
		s_phase_up_top ##1 1'b1 |-> counting_down ##1 (cnt_we || !run || counting_down))
		else $error("phase counter did not turn at top");

	a_preset_wave: assert property (
		preset_we |=> wave_out_a == $past(pwdata[WAVE_A_BIT]))
		else $error("waveform preset not taken");

	a_apb_answer: assert property (
		psel && !penable |=> !penable || pready)
		else $error("apb access phase not answered");

	// ********************************
	// further channel and counter checks
	// ********************************
	a_override_a: assert property (
		cmp_out_mode_a == 2'b00 |-> wave_pin_a == port_data_a)
		else $error("pin a not showing port data");

	// forced actions apply only outside the PWM kinds
	a_force_clear: assert property (
		force_b && !pwm_fast && !pwm_phase && cmp_out_mode_b == 2'b10 |=> !wave_out_b)
		else $error("forced clear not applied");

	a_force_pwm: assert property (
		s_pwm_force |=> $stable(wave_out_b))
		else $error("force acted in pwm mode");

	// a mode write alone never moves the output; the next match or fast PWM TOP does
	a_mode_late: assert property (
		bus_wr && paddr == OFF_CONTROL_A && !match_b && !(run && at_top)
		|=> $stable(wave_out_b))
		else $error("mode write acted before a match");

	a_toggle_a: assert property (
		match_a && !pwm_fast && !pwm_phase && cmp_out_mode_a == 2'b01 && !bus_wr
		|=> wave_out_a != $past(wave_out_a))
		else $error("channel a toggle missing");

	a_fast_reserved: assert property (
		pwm_fast && cmp_out_mode_b == 2'b01 && !bus_wr |=> $stable(wave_out_b))
		else $error("reserved fast pwm code acted");

	a_phase_down: assert property (
		pwm_phase && match_b && counting_down && cmp_out_mode_b == 2'b10 && !bus_wr
		|=> wave_out_b)
		else $error("phase pwm down-count action wrong");

	a_phase_at_top: assert property (
		pwm_phase && match_b && at_top && cmp_out_mode_b == 2'b10 && !bus_wr |=> wave_out_b)
		else $error("phase pwm top match not taken as top action");

	// counter end points
	a_ctc_wrap: assert property (
		s_ctc_top |=> count == COUNT_BOTTOM)
		else $error("clear on match mode did not wrap at top");

	a_count_hold: assert property (
		!run && !cnt_we |=> $stable(count))
		else $error("stopped counter moved");

endmodule : timer8_compare_output_unit

`default_nettype wire

/* File: test/pin_model.sv */
/*
 * Pad model for one waveform pin: resolves the level seen on the board.
 * Assumes the unit hands over a pin value and an active-high output enable.
 */
`timescale 1ns/10ps
`default_nettype none

// ********************************
// pad with weak pull-up
// ********************************
module pin_model (
	input wire logic pin_val,
	input wire logic pin_oe,
	output logic pad
);
	// a released pad goes to the pull-up, never to the last driven value
	assign pad = pin_oe ? pin_val : 1'b1;
endmodule : pin_model

`default_nettype wire

/* File: test/tb.sv */
/*
 * Self-checking bench for the timer compare output unit: APB register
 * access, port override, forced and real compare actions, PWM duty.
 * Assumes the zero-wait APB slave and the register map of the package.
 */
`timescale 1ns/10ps
`default_nettype none

module tb import timer8_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pd_a = 1'b0;
	logic pd_b = 1'b0;
	logic dir_a = 1'b1;
	logic dir_b = 1'b1;
	logic pin_a, oe_a, pin_b, oe_b, pad_a, pad_b;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;

	// ********************************
	// design and pads
	// ********************************
	timer8_compare_output_unit dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_data_a(pd_a), .port_data_b(pd_b),
		.wave_pin_direction_a(dir_a), .wave_pin_direction_b(dir_b),
		.wave_pin_a(pin_a), .wave_pin_a_oe(oe_a), .wave_pin_b(pin_b), .wave_pin_b_oe(oe_b)
	);
	pin_model pad_model_a (.pin_val(pin_a), .pin_oe(oe_a), .pad(pad_a));
	pin_model pad_model_b (.pin_val(pin_b), .pin_oe(oe_b), .pad(pad_b));

	// clock, and a cycle ceiling so a hung handshake still ends the run
	initial forever #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	// ********************************
	// shared tasks
	// ********************************
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one APB transfer; request held until pready is seen high at an edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	// pins are combinational: look at them away from the launching edge
	task settle();
		@(negedge pclk);
	endtask : settle

	// ********************************
	// scenarios
	// ********************************
	task s_regs();
		apb(1'b0, OFF_CONTROL_A, 32'h0000_0000);
		chk("control a reset", rd, 32'h0000_0000);
		wr(OFF_CONTROL_A, 32'h0000_00FF);
		apb(1'b0, OFF_CONTROL_A, 32'h0000_0000);
		chk("control a reserved", rd, 32'(CONTROL_A_READ_MASK));
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped error", 32'(er), 32'h0000_0001);
		chk("unmapped data", rd, 32'h0000_0000);
		wr(OFF_CONTROL_A, 32'h0000_0000);
	endtask : s_regs

	task s_override();
		@(posedge pclk);
		pd_b <= 1'b1;
		pd_a <= 1'b1;
		wr(OFF_WAVE, 32'h0000_0000);
		settle();
		chk("pin b port data", 32'(pad_b), 32'h0000_0001);
		wr(OFF_CONTROL_A, 32'h0000_0020);
		settle();
		chk("pin b wave bit", 32'(pad_b), 32'h0000_0000);
		wr(OFF_CONTROL_A, 32'h0000_00E3);
		settle();
		chk("pin b in fast mode", 32'(pad_b), 32'h0000_0000);
		chk("pin a wave bit", 32'(pad_a), 32'h0000_0000);
		@(posedge pclk);
		dir_b <= 1'b0;
		settle();
		chk("pin b enable", 32'(oe_b), 32'h0000_0000);
		chk("pin b released", 32'(pad_b), 32'h0000_0001);
		@(posedge pclk);
		dir_b <= 1'b1;
		pd_b <= 1'b0;
	endtask : s_override

	// every non-PWM code forced once, then a force in PWM that must be ignored
	task s_force();
		logic [3:0] exp;
		logic [1:0] p;
		exp = 4'b1001;
		for (int m = 0; m < 4; m++) begin
			p = (m == 3) ? 2'b00 : 2'b10;
			wr(OFF_WAVE, 32'(p));
			wr(OFF_CONTROL_A, 32'(m << 4));
			wr(OFF_CONTROL_B, 32'h0000_0040);
			apb(1'b0, OFF_WAVE, 32'h0000_0000);
			chk("forced wave b", 32'(rd[1]), 32'(exp[m]));
		end
		wr(OFF_WAVE, 32'h0000_0002);
		wr(OFF_CONTROL_A, 32'h0000_0023);
		wr(OFF_CONTROL_B, 32'h0000_0040);
		apb(1'b0, OFF_WAVE, 32'h0000_0000);
		chk("force in pwm", 32'(rd[1]), 32'h0000_0001);
	endtask : s_force

	task s_match();
		wr(OFF_CONTROL_B, 32'h0000_0000);
		wr(OFF_CMP_B, 32'h0000_0020);
		wr(OFF_COUNT, 32'h0000_0010);
		wr(OFF_WAVE, 32'h0000_0002);
		wr(OFF_CONTROL_A, 32'h0000_0020);
		settle();
		chk("no action before match", 32'(pad_b), 32'h0000_0001);
		wr(OFF_CONTROL_B, 32'h0000_0001);
		repeat (40) @(posedge pclk);
		wr(OFF_CONTROL_B, 32'h0000_0000);
		apb(1'b0, OFF_WAVE, 32'h0000_0000);
		chk("cleared at match", 32'(rd[1]), 32'h0000_0000);
	endtask : s_match

	// duty is counted over one whole period once the waveform has settled
	task pwm_run(input logic [2:0] gen, input logic [1:0] mode, input logic [7:0] cmp,
		input logic pre, input int period, input int exp_hi);
		int hi;
		hi = 0;
		wr(OFF_CONTROL_B, 32'h0000_0000);
		wr(OFF_COUNT, 32'h0000_0000);
		wr(OFF_CMP_B, 32'(cmp));
		wr(OFF_WAVE, 32'({pre, 1'b0}));
		wr(OFF_CONTROL_A, 32'({2'b00, mode, 2'b00, gen[1:0]}));
		wr(OFF_CONTROL_B, 32'({gen[2], 3'b001})); // third generation bit sits in control b
		repeat (period + 3) @(negedge pclk);
		repeat (period) begin
			@(negedge pclk);
			hi += int'(pad_b);
		end
		chk("high cycles", 32'(hi), 32'(exp_hi));
	endtask : pwm_run

	// clear-on-match counting with top from compare A, toggles, then a zero mode
	task s_ctc();
		int ha;
		int hb;
		logic b1;
		ha = 0;
		hb = 0;
		wr(OFF_CONTROL_B, 32'h0000_0000);
		wr(OFF_COUNT, 32'h0000_0000);
		wr(OFF_CMP_A, 32'h0000_0009);
		wr(OFF_CMP_B, 32'h0000_0004);
		wr(OFF_WAVE, 32'h0000_0001);
		wr(OFF_CONTROL_A, 32'h0000_0052);
		wr(OFF_CONTROL_B, 32'h0000_0001);
		repeat (40) begin
			@(negedge pclk);
			ha += int'(pad_a);
			hb += int'(pad_b);
		end
		chk("toggle a high cycles", 32'(ha), 32'h0000_0014);
		chk("toggle b high cycles", 32'(hb), 32'h0000_0014);
		apb(1'b0, OFF_COUNT, 32'h0000_0000);
		chk("count below top", 32'(rd[7:0] <= 8'h09), 32'h0000_0001);
		wr(OFF_CONTROL_A, 32'h0000_0042);
		apb(1'b0, OFF_WAVE, 32'h0000_0000);
		b1 = rd[1];
		repeat (30) @(posedge pclk);
		apb(1'b0, OFF_WAVE, 32'h0000_0000);
		chk("mode zero wave b", 32'(rd[1]), 32'(b1));
		wr(OFF_CONTROL_A, 32'h0000_0000);
		wr(OFF_CONTROL_B, 32'h0000_0000);
	endtask : s_ctc

	// reset while the counter runs: pins fall back to port data, state clears
	task s_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk("pin a port after reset", 32'(pad_a), 32'h0000_0001);
		apb(1'b0, OFF_WAVE, 32'h0000_0000);
		chk("wave after reset", rd, 32'h0000_0000);
		apb(1'b0, OFF_COUNT, 32'h0000_0000);
		chk("count after reset", rd, 32'h0000_0000);
	endtask : s_reset

	task test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// ********************************
	// main sequence
	// ********************************
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_override();
		s_force();
		s_match();
		pwm_run(3'd3, 2'b10, 8'h80, 1'b0, 256, 129);
		pwm_run(3'd3, 2'b11, 8'h80, 1'b0, 256, 127);
		pwm_run(3'd3, 2'b01, 8'h80, 1'b1, 256, 256);
		pwm_run(3'd3, 2'b10, 8'hFF, 1'b0, 256, 256);
		pwm_run(3'd1, 2'b10, 8'h80, 1'b0, 510, 256);
		pwm_run(3'd1, 2'b11, 8'h80, 1'b0, 510, 254);
		pwm_run(3'd1, 2'b10, 8'hFF, 1'b0, 510, 510);
		s_ctc();
		pwm_run(3'd7, 2'b10, 8'h04, 1'b0, 10, 5);
		pwm_run(3'd5, 2'b10, 8'h04, 1'b0, 18, 8);
		s_reset();
		test_done();
	end
endmodule : tb

`default_nettype wire
